// ---- pkg/ddr2_pkg.sv ----
package ddr2_pkg;
	// command encoding {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_DESELECT = 4'h8;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_ACTIVATE = 4'h3;
	localparam logic [3:0] CMD_READ = 4'h5;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_REFRESH = 4'h1;
	localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
	localparam int ADDR_W = 14;
	localparam int BANK_W = 3;
	localparam int DATA_W = 8;
	localparam int CLK_PERIOD_NS = 100;
	// register selection on bank lines
	localparam logic [2:0] SEL_MR = 3'h0;
	localparam logic [2:0] SEL_EMR = 3'h1;
	localparam logic [2:0] SEL_EMR2 = 3'h2;
	localparam logic [2:0] SEL_EMR3 = 3'h3;
	localparam int BIT_ALL_BANKS = 10;
	localparam int BIT_DLL_RESET = 8;
	localparam int BIT_SRF_RATE = 7;
	localparam int BIT_DLL_DISABLE = 0;
	localparam logic [13:0] OCD_DEFAULT_BITS = 14'h0380;
	localparam int CL_LSB = 4;
	localparam int AL_LSB = 3;
	localparam int BL_LSB = 0;
	// timing figures and derived cycle counts
	localparam int T_STABLE_NS = 200000;
	localparam int T_CKE_PRE_NS = 400;
	localparam int T_RCD_NS = 15;
	localparam int T_RC_NS = 55;
	localparam int T_RRD_NS = 10;
	localparam int T_FAW_NS = 50;
	localparam int T_RP_NS = 15;
	localparam int T_RFC_NS = 128;
	localparam int T_MRD_CYC = 2;
	localparam int T_STABLE_CYC = (T_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_CKE_PRE_CYC = (T_CKE_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RC_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RRD_CYC = (T_RRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_FAW_CYC = (T_FAW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_RFC_CYC = (T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DLL_LOCK_CYC = 200;
	localparam int REFRESH_COUNT = 2;
	// defaults of the operating mode
	localparam logic [2:0] DEF_CL = 3'h3;
	localparam logic [2:0] DEF_AL = 3'h0;
	localparam logic [2:0] DEF_BL_CODE = 3'h2;
endpackage

// ---- pkg/ddr2_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface ddr2_if;
	import ddr2_pkg::*;
	logic ck;
	logic cke;
	logic [3:0] cmd;
	logic [BANK_W-1:0] ba;
	logic [ADDR_W-1:0] addr;
	logic [2*DATA_W-1:0] dq_rd;
	logic dqs_pre;
	logic dq_oe;
	logic dq_first;
	modport ctrl (output ck, output cke, output cmd, output ba, output addr,
		input dq_rd, input dqs_pre, input dq_oe, input dq_first);
	modport mem (input ck, input cke, input cmd, input ba, input addr,
		output dq_rd, output dqs_pre, output dq_oe, output dq_first);
endinterface
`default_nettype wire

// ---- verilog/ddr2_gap_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module ddr2_gap_timer #(
	parameter int WIDTH = 18
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	input wire logic load_i,
	input wire logic [WIDTH-1:0] count_i,
	output logic done_o
);
	logic [WIDTH-1:0] remain;
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			remain <= '0;
		end else if (load_i) begin
			remain <= count_i;
		end else if (remain != '0) begin
			remain <= remain - 1'b1;
		end
	end
	assign done_o = (remain == '0) && !load_i;
endmodule
`default_nettype wire

// ---- verilog/ddr2_mem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module ddr2_mem_model
	import ddr2_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	ddr2_if.mem link,
	// status
	output logic READY_O,
	output logic DLL_LOCKED_O
);
	localparam int LAT_MAX = 16;
	logic [ADDR_W-1:0] mr;
	logic [ADDR_W-1:0] emr;
	logic [7:0] lock_cnt;
	logic locking;
	logic [3:0] rl;
	logic [2:0] bl_pairs;
	logic [LAT_MAX-1:0] issue_pipe;
	logic [2:0] pairs_left;
	logic [ADDR_W-1:0] col;
	logic [2:0] pair_idx;
	logic taken;
	logic [2*DATA_W-1:0] mem [DEPTH];

	// sampled only on the rising true edge while cke is high
	assign taken = link.cke && (link.cmd != CMD_DESELECT) && (link.cmd != CMD_NOP);
	assign rl = 4'(mr[CL_LSB +: 3]) + 4'(emr[AL_LSB +: 3]);
	assign bl_pairs = (mr[BL_LSB +: 3] == 3'h3) ? 3'h4 : 3'h2;

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			mr <= '0;
			emr <= '0;
		end else if (taken && link.cmd == CMD_LOAD_MODE) begin
			// the register is chosen by decoded bank lines
			if (link.ba == SEL_MR) mr <= link.addr;
			if (link.ba == SEL_EMR) emr <= link.addr;
		end
	end

	// dll locks 200 cycles after a reset load, readiness rises on the same edge
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			lock_cnt <= '0;
			locking <= 1'b0;
			DLL_LOCKED_O <= 1'b0;
			READY_O <= 1'b0;
		end else if (taken && link.cmd == CMD_LOAD_MODE && link.ba == SEL_MR
			&& link.addr[BIT_DLL_RESET]) begin
			lock_cnt <= 8'(DLL_LOCK_CYC - 1);
			locking <= 1'b1;
			DLL_LOCKED_O <= 1'b0;
			READY_O <= 1'b0;
		end else if (locking) begin
			if (lock_cnt == 8'h00) begin
				locking <= 1'b0;
				DLL_LOCKED_O <= 1'b1;
				READY_O <= 1'b1;
			end else begin
				lock_cnt <= lock_cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			issue_pipe <= '0;
		end else begin
			issue_pipe <= {issue_pipe[LAT_MAX-2:0], taken && link.cmd == CMD_READ};
		end
	end

	// a fresh read restarts the burst, so truncation and concatenation both fall out
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			pairs_left <= '0;
			pair_idx <= '0;
			col <= '0;
		end else if (taken && link.cmd == CMD_READ) begin
			col <= link.addr;
		// load one cycle early so the first pair is sampled exactly rl edges after the read
		end else if (rl > 4'h1 && issue_pipe[rl-2]) begin
			pairs_left <= bl_pairs;
			pair_idx <= '0;
		end else if (pairs_left != '0) begin
			pairs_left <= pairs_left - 1'b1;
			pair_idx <= pair_idx + 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= (2*DATA_W)'(i);
			end
		end
	end

	// one pair of elements per clock, on both edges strobe low preamble
	assign link.dq_first = (pair_idx == 3'h0) && (pairs_left != '0);
	assign link.dq_oe = (pairs_left != '0); // released when no burst follows
	assign link.dqs_pre = (rl > 4'h1) && issue_pipe[rl-2];
	assign link.dq_rd = mem[4'(col) + 4'(pair_idx)];
endmodule
`default_nettype wire

// ---- verilog/ddr2_init_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module ddr2_init_ctrl
	import ddr2_pkg::*;
#(
	parameter int STABLE_CYC = T_STABLE_CYC,
	parameter logic SRF_FAST = 1'b0
) (
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	ddr2_if.ctrl link,
	// read request
	input wire logic READ_REQ_I,
	input wire logic [BANK_W-1:0] READ_BANK_I,
	input wire logic [ADDR_W-1:0] READ_ROW_I,
	input wire logic [ADDR_W-1:0] READ_COL_I,
	output logic READ_ACK_O,
	// read data
	output logic [2*DATA_W-1:0] READ_DATA_O,
	output logic READ_VALID_O,
	// status
	output logic INIT_DONE_O
);
	typedef enum {
		S_WAIT_STABLE, S_WAIT_CKE, S_PRE1, S_EMR2, S_EMR3, S_EMR_DLL, S_MR_RESET,
		S_PRE2, S_REF, S_MR_OP, S_OCD_DEF, S_OCD_EXIT, S_WAIT_LOCK, S_IDLE,
		S_ACT, S_READ, S_DRAIN
	} state_type;
	state_type state;
	logic [17:0] wait_cnt;
	logic load;
	logic gap_done;
	logic [1:0] ref_cnt;
	logic [7:0] lock_cnt;
	logic [3:0] rc_cnt;
	logic [3:0] rrd_cnt;
	logic [2:0] faw_hist [4];
	logic act_issue;
	logic [3:0] drain_cnt;
	logic [ADDR_W-1:0] mr_op;
	logic [BANK_W-1:0] last_bank;
	logic [ADDR_W-1:0] col_hold;

	assign mr_op = ADDR_W'({DEF_CL, 1'b0, DEF_BL_CODE}) << BL_LSB;
	assign act_issue = (state == S_ACT) && gap_done && (rc_cnt == '0 || last_bank != READ_BANK_I)
		&& rrd_cnt == '0 && faw_hist[3] == '0;

	ddr2_gap_timer #(.WIDTH(18)) gap (
		.SYS_CLK_I(SYS_CLK_I),
		.RST_I(RST_I),
		.load_i(load),
		.count_i(wait_cnt),
		.done_o(gap_done)
	);

	assign link.ck = SYS_CLK_I;

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			state <= S_WAIT_STABLE;
			link.cke <= 1'b0;
			link.cmd <= CMD_NOP;
			link.ba <= '0;
			link.addr <= '0;
			load <= 1'b1;
			wait_cnt <= 18'(STABLE_CYC);
			ref_cnt <= '0;
			INIT_DONE_O <= 1'b0;
			READ_ACK_O <= 1'b0;
			col_hold <= '0;
		end else begin
			link.cmd <= CMD_NOP;
			load <= 1'b0;
			READ_ACK_O <= 1'b0;
			if (gap_done && !load) begin
				case (state)
				S_WAIT_STABLE: begin
					link.cke <= 1'b1;
					load <= 1'b1;
					wait_cnt <= 18'(T_CKE_PRE_CYC);
					state <= S_WAIT_CKE;
				end
				S_WAIT_CKE: begin
					link.cmd <= CMD_PRECHARGE;
					link.addr <= ADDR_W'(1) << BIT_ALL_BANKS;
					load <= 1'b1;
					wait_cnt <= 18'(T_RP_CYC);
					state <= S_EMR2;
				end
				S_EMR2: begin
					link.cmd <= CMD_LOAD_MODE;
					link.ba <= SEL_EMR2;
					link.addr <= ADDR_W'(SRF_FAST) << BIT_SRF_RATE;
					load <= 1'b1;
					wait_cnt <= 18'(T_MRD_CYC);
					state <= S_EMR3;
				end
				S_EMR3: begin
					link.cmd <= CMD_LOAD_MODE;
					link.ba <= SEL_EMR3;
					link.addr <= '0;
					load <= 1'b1;
					wait_cnt <= 18'(T_MRD_CYC);
					state <= S_EMR_DLL;
				end
				S_EMR_DLL: begin
					link.cmd <= CMD_LOAD_MODE;
					link.ba <= SEL_EMR;
					link.addr <= ADDR_W'(DEF_AL) << AL_LSB;
					load <= 1'b1;
					wait_cnt <= 18'(T_MRD_CYC);
					state <= S_MR_RESET;
				end
				S_MR_RESET: begin
					link.cmd <= CMD_LOAD_MODE;
					link.ba <= SEL_MR;
					link.addr <= ADDR_W'(1) << BIT_DLL_RESET;
					load <= 1'b1;
					wait_cnt <= 18'(T_MRD_CYC);
					state <= S_PRE2;
				end
				S_PRE2: begin
					link.cmd <= CMD_PRECHARGE;
					link.ba <= '0;
					link.addr <= ADDR_W'(1) << BIT_ALL_BANKS;
					load <= 1'b1;
					wait_cnt <= 18'(T_RP_CYC);
					state <= S_REF;
				end
				S_REF: begin
					link.cmd <= CMD_REFRESH;
					ref_cnt <= ref_cnt + 1'b1;
					load <= 1'b1;
					wait_cnt <= 18'(T_RFC_CYC);
					if (ref_cnt == 2'(REFRESH_COUNT - 1)) state <= S_MR_OP;
				end
				S_MR_OP: begin
					link.cmd <= CMD_LOAD_MODE;
					link.ba <= SEL_MR;
					link.addr <= mr_op;
					load <= 1'b1;
					wait_cnt <= 18'(T_MRD_CYC);
					state <= S_OCD_DEF;
				end
				S_OCD_DEF: begin
					link.cmd <= CMD_LOAD_MODE;
					link.ba <= SEL_EMR;
					link.addr <= OCD_DEFAULT_BITS | (ADDR_W'(DEF_AL) << AL_LSB);
					load <= 1'b1;
					wait_cnt <= 18'(T_MRD_CYC);
					state <= S_OCD_EXIT;
				end
				S_OCD_EXIT: begin
					link.cmd <= CMD_LOAD_MODE;
					link.ba <= SEL_EMR;
					link.addr <= ADDR_W'(DEF_AL) << AL_LSB;
					load <= 1'b1;
					wait_cnt <= 18'(T_MRD_CYC);
					state <= S_WAIT_LOCK;
				end
				S_WAIT_LOCK: begin
					if (lock_cnt == '0) begin
						INIT_DONE_O <= 1'b1;
						state <= S_IDLE;
					end
				end
				S_IDLE: begin
					if (READ_REQ_I) begin
						col_hold <= READ_COL_I;
						state <= S_ACT;
					end
				end
				S_ACT: begin
					if (act_issue) begin
						link.cmd <= CMD_ACTIVATE;
						link.ba <= READ_BANK_I;
						link.addr <= READ_ROW_I;
						load <= 1'b1;
						wait_cnt <= 18'(T_RCD_CYC);
						state <= S_READ;
					end
				end
				S_READ: begin
					link.cmd <= CMD_READ;
					// auto precharge closes the row, so the next activate may reuse the bank
					link.addr <= col_hold | (ADDR_W'(1) << BIT_ALL_BANKS);
					READ_ACK_O <= 1'b1;
					state <= S_DRAIN;
				end
				S_DRAIN: begin
					if (drain_cnt == '0) state <= S_IDLE;
				end
				default: state <= S_WAIT_STABLE;
				endcase
			end
		end
	end

	// dll lock wait runs from the reset load alongside later commands
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			lock_cnt <= '0;
		end else if (state == S_MR_RESET && gap_done && !load) begin
			lock_cnt <= 8'(DLL_LOCK_CYC);
		end else if (lock_cnt != '0) begin
			lock_cnt <= lock_cnt - 1'b1;
		end
	end

	// activate spacing: rc per bank last used, rrd any bank, rolling four-slot window
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			rc_cnt <= '0;
			rrd_cnt <= '0;
			last_bank <= '0;
			for (int i = 0; i < 4; i++) faw_hist[i] <= '0;
		end else begin
			rc_cnt <= act_issue ? 4'(T_RC_CYC - 1) : (rc_cnt != '0 ? rc_cnt - 1'b1 : rc_cnt);
			rrd_cnt <= act_issue ? 4'(T_RRD_CYC - 1) : (rrd_cnt != '0 ? rrd_cnt - 1'b1 : rrd_cnt);
			if (act_issue) last_bank <= READ_BANK_I;
			if (act_issue) begin
				faw_hist[0] <= 3'(T_FAW_CYC - 1);
			end else if (faw_hist[0] != '0) begin
				faw_hist[0] <= faw_hist[0] - 1'b1;
			end
			for (int i = 1; i < 4; i++) begin
				if (act_issue) begin
					faw_hist[i] <= (faw_hist[i-1] != '0) ? faw_hist[i-1] - 1'b1 : '0;
				end else if (faw_hist[i] != '0) begin
					faw_hist[i] <= faw_hist[i] - 1'b1;
				end
			end
		end
	end

	// wait out the whole burst: latency plus five cycles for the two pairs and a turnaround
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			drain_cnt <= '0;
		end else if (state == S_READ && gap_done && !load) begin
			drain_cnt <= 4'(DEF_CL) + 4'(DEF_AL) + 4'h5;
		end else if (drain_cnt != '0) begin
			drain_cnt <= drain_cnt - 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			READ_DATA_O <= '0;
			READ_VALID_O <= 1'b0;
		end else begin
			READ_DATA_O <= link.dq_rd;
			READ_VALID_O <= link.dq_oe;
		end
	end
endmodule
`default_nettype wire

// ---- tb/ddr2_link_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module ddr2_link_sva
	import ddr2_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// link
	input wire logic cke,
	input wire logic [3:0] cmd,
	input wire logic [BANK_W-1:0] ba,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic dqs_pre,
	input wire logic dq_oe,
	input wire logic dq_first
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);
	logic [7:0] open_bank;
	logic busy;
	assign busy = (cmd != CMD_NOP) && !cmd[3];
	// auto precharge on a read closes the row as well
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			open_bank <= '0;
		end else if (cmd == CMD_ACTIVATE) begin
			open_bank[ba] <= 1'b1;
		end else if (cmd == CMD_PRECHARGE && addr[BIT_ALL_BANKS]) begin
			open_bank <= '0;
		end else if (cmd == CMD_PRECHARGE || (cmd == CMD_READ && addr[BIT_ALL_BANKS])) begin
			open_bank[ba] <= 1'b0;
		end
	end
	nop_cke_low_a: assert property (!cke |-> !busy)
		else $error("command issued while cke low");
	cke_hold_a: assert property ($past(cke) |-> cke)
		else $error("cke dropped after rising");
	cke_wait_a: assert property ($rose(cke) |-> (!busy) [*4] ##[1:20] (cmd == CMD_PRECHARGE && addr[BIT_ALL_BANKS]))
		else $error("precharge all not after cke wait");
	emr2_bits_a: assert property (cmd == CMD_LOAD_MODE && ba == SEL_EMR2 |-> (addr & ~14'h0080) == 14'h0000)
		else $error("emr2 reserved bits set");
	emr3_zero_a: assert property (cmd == CMD_LOAD_MODE && ba == SEL_EMR3 |-> addr == 14'h0000)
		else $error("emr3 not zero");
	dll_then_prea_a: assert property (cmd == CMD_LOAD_MODE && ba == SEL_MR && addr[BIT_DLL_RESET] |-> ##[1:10] (cmd == CMD_PRECHARGE && addr[BIT_ALL_BANKS]))
		else $error("no precharge all after dll reset");
	ocd_exit_a: assert property (cmd == CMD_LOAD_MODE && ba == SEL_EMR && addr[9:7] == 3'h7 |-> ##[1:10] (cmd == CMD_LOAD_MODE && ba == SEL_EMR && addr[9:7] == 3'h0))
		else $error("ocd default not followed by exit");
	act_first_a: assert property (cmd == CMD_READ |-> open_bank[ba])
		else $error("read to bank without open row");
	act_closed_a: assert property (cmd == CMD_ACTIVATE |-> !open_bank[ba])
		else $error("activate to bank with open row");
	read_lat_a: assert property (cmd == CMD_READ |-> ##3 (dq_oe && dq_first))
		else $error("read data not at read latency");
	preamble_a: assert property ($rose(dq_oe) |-> $past(dqs_pre))
		else $error("no strobe preamble before data");
	burst_len_a: assert property ($rose(dq_oe) |-> dq_oe ##1 dq_oe ##1 !dq_oe)
		else $error("data lines held beyond burst");
	cmd_cke_a: assert property (busy |-> cke)
		else $error("command sampled with cke low");
	cover property ($rose(cke));
	cover property (cmd == CMD_LOAD_MODE && ba == SEL_MR && addr[BIT_DLL_RESET]);
	cover property (cmd == CMD_READ);
	cover property ($rose(dq_oe));
endmodule
`default_nettype wire

// ---- tb/ddr2_init_activate_read_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module ddr2_init_activate_read_test;
	import ddr2_pkg::*;
	logic clk = 0, rst = 1, req = 0, ack, valid, done, ready;
	logic [2:0] bank = 0;
	logic [13:0] row = 0, col = 0;
	logic [15:0] data;
	int n_errors = 0, samples_checked = 0, seed = 96, cyc, t_dll, t_rdy, t_cke, early_ack;
	logic [20:0] seen [$];
	logic [3:0] e_cmd [11] = '{4'h2, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
	logic [2:0] e_sel [11] = '{0, 2, 3, 1, 0, 0, 0, 0, 0, 1, 1};
	logic [13:0] e_msk [11] = '{14'h0400, 14'h3FFF, 14'h3FFF, 14'h3FFF, 14'h3FFF, 14'h0400,
		14'h0000, 14'h0000, 14'h0100, 14'h0380, 14'h0380};
	logic [13:0] e_val [11] = '{14'h0400, 0, 0, 0, 14'h0100, 14'h0400, 0, 0, 0, 14'h0380, 0};
	ddr2_if bus ();
	ddr2_init_ctrl #(.STABLE_CYC(20), .SRF_FAST(1'b0)) ddr2_init_ctrl_inst (.SYS_CLK_I(clk),
		.RST_I(rst), .link(bus), .READ_REQ_I(req), .READ_BANK_I(bank), .READ_ROW_I(row),
		.READ_COL_I(col), .READ_ACK_O(ack), .READ_DATA_O(data), .READ_VALID_O(valid),
		.INIT_DONE_O(done));
	ddr2_mem_model ddr2_mem_model_inst (.SYS_CLK_I(clk), .RST_I(rst), .link(bus),
		.READY_O(ready), .DLL_LOCKED_O());
	ddr2_link_sva ddr2_link_sva_inst (.SYS_CLK_I(clk), .RST_I(rst), .cke(bus.cke), .cmd(bus.cmd),
		.ba(bus.ba), .addr(bus.addr), .dqs_pre(bus.dqs_pre), .dq_oe(bus.dq_oe),
		.dq_first(bus.dq_first));
	initial begin
		forever #50 clk = ~clk;
	end
	// init command log, cycle stamps and acks seen before init ends
	always @(posedge clk) begin
		cyc <= rst ? 0 : cyc + 1;
		if (rst) begin
			seen.delete();
			early_ack <= 0;
			t_cke <= -1;
			t_rdy <= -1;
		end else if (!done) begin
			if (bus.cmd != CMD_NOP && !bus.cmd[3]) seen.push_back({bus.cmd, bus.ba, bus.addr});
			if (bus.cmd == CMD_LOAD_MODE && bus.ba == SEL_MR && bus.addr[8]) t_dll <= cyc;
			if (bus.cke && t_cke < 0) t_cke <= cyc;
			if (ack) early_ack <= 1;
		end
		// readiness lands on the edge that ends init, so it is logged outside the init window
		if (!rst && ready && t_rdy < 0) t_rdy <= cyc;
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (exp !== got) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_sim;
		if (n_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// the first request of each pass is raised before init ends so it must be held off until then
	task automatic do_read(input logic [2:0] b, input logic [13:0] r, input logic [13:0] c);
		int k;
		req <= 1'b1;
		bank <= b;
		row <= r;
		col <= c;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 1000);
		req <= 1'b0;
		chk("ack", 1, ack);
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (valid !== 1'b1 && k < 20);
		for (int w = 0; w < 2; w++) begin
			chk("valid", 1, valid);
			chk("data", {12'h000, 4'(c[3:0] + 4'(w))}, data);
			@(posedge clk);
		end
		chk("valid_end", 0, valid);
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		n_errors++;
		end_sim();
	end
	initial begin
		for (int pass = 0; pass < 2; pass++) begin
			rst <= 1'b1;
			repeat (12) @(posedge clk);
			rst <= 1'b0;
			do_read(3'($random(seed)), 14'($random(seed)), {12'($random(seed)), 2'h0});
			chk("early_ack", 0, 16'(early_ack));
			chk("ready", 1, ready);
			chk("dll_wait", 201, 16'(t_rdy - t_dll));
			chk("cke_wait", 1, 16'(t_cke >= 20));
			chk("init_len", 11, 16'(seen.size()));
			for (int i = 0; i < 11 && i < seen.size(); i++) begin
				chk("init_cmd", e_cmd[i], seen[i][20:17]);
				if (e_cmd[i] == CMD_LOAD_MODE) chk("init_sel", e_sel[i], seen[i][16:14]);
				chk("init_addr", e_val[i], seen[i][13:0] & e_msk[i]);
			end
			for (int n = 0; n < 5; n++)
				do_read(3'($random(seed)), 14'($random(seed)), {12'($random(seed)), 2'h0});
		end
		end_sim();
	end
endmodule
`default_nettype wire
